// ===== sfd_consts.vh
`ifndef SFD_CONSTS_VH
`define SFD_CONSTS_VH
// ==========================================================
// register map
`define SFD_ADDR_W 3
`define SFD_OFS_FORMAT 3'h0
`define SFD_OFS_DIVISOR 3'h1
`define SFD_OFS_CONTROL 3'h2
`define SFD_OFS_TXHOLD 3'h3
`define SFD_OFS_STATUS 3'h4
`define SFD_OFS_RXHOLD 3'h5
// ==========================================================
// serial_format fields
`define SFD_FMT_SYNC 7
`define SFD_FMT_SEVEN 6
`define SFD_FMT_PAREN 5
`define SFD_FMT_ODD 4
`define SFD_FMT_STOP2 3
`define SFD_FMT_MP 2
`define SFD_FMT_CKS_HI 1
`define SFD_FMT_CKS_LO 0
// ==========================================================
// control fields
`define SFD_CTL_TXEN 0
`define SFD_CTL_RXEN 1
// ==========================================================
// status fields
`define SFD_ST_TXEMPTY 7
`define SFD_ST_RXFULL 6
`define SFD_ST_OVERRUN 5
`define SFD_ST_FRAMING 4
`define SFD_ST_PARITY 3
`define SFD_ST_TXEND 2
`define SFD_ST_MPB_RX 1
`define SFD_ST_MPB_TX 0
// ==========================================================
// reset values
`define SFD_RST_RXHOLD 8'h00
`define SFD_RST_TXHOLD 8'hff
`define SFD_RST_FORMAT 8'h00
`define SFD_RST_DIVISOR 8'hff
`define SFD_RST_CONTROL 8'h00
`define SFD_ZERO8 8'h00
// ==========================================================
// bit timing, in baud ticks
`define SFD_PH_LAST 4'hf
`define SFD_PH_MID 4'h7
`define SFD_IDX_LAST8 3'h7
`define SFD_IDX_LAST7 3'h6
// ==========================================================
// prescaler masks: phi, phi/4, phi/16, phi/64
`define SFD_PRE_M0 6'h00
`define SFD_PRE_M1 6'h03
`define SFD_PRE_M2 6'h0f
`define SFD_PRE_M3 6'h3f
`endif

// ===== sfd_baud_gen.v
`timescale 1ns/1ps
`default_nettype none
`include "sfd_consts.vh"
module sfd_baud_gen #(
    parameter DIV_W = 8
) (
    input wire clock_in, // system clock
    input wire rst_in, // sync reset, high
    input wire ce_in, // clock enable
    input wire [1:0] sel_in, // prescale select
    input wire [DIV_W-1:0] divisor_in, // divisor+1 pulses a tick
    output reg prescale_out, // prescaler pulse
    output reg tick_out // baud tick, one cycle
);
    reg [5:0] pre_cnt_r;
    reg [DIV_W-1:0] div_cnt_r;
    reg [5:0] mask;
    wire pre_hit;

    always @* begin
        case (sel_in)
            2'h0: mask = `SFD_PRE_M0;
            2'h1: mask = `SFD_PRE_M1;
            2'h2: mask = `SFD_PRE_M2;
            default: mask = `SFD_PRE_M3;
        endcase
    end

    assign pre_hit = ((pre_cnt_r & mask) == mask);

    // ==========================================================
    // prescaler and divisor
    always @(posedge clock_in) begin
        if (rst_in) begin
            pre_cnt_r <= 6'h00;
            div_cnt_r <= {DIV_W{1'b0}};
            prescale_out <= 1'b0;
            tick_out <= 1'b0;
        end else if (ce_in) begin
            pre_cnt_r <= pre_cnt_r + 6'h01;
            prescale_out <= pre_hit;
            tick_out <= 1'b0;
            if (pre_hit) begin
                if (div_cnt_r >= divisor_in) begin
                    div_cnt_r <= {DIV_W{1'b0}};
                    tick_out <= 1'b1;
                end else begin
                    div_cnt_r <= div_cnt_r + {{(DIV_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== sfd_serial_unit.v
// Operation
// RULE1: rx_shifter assembles frame, moves to rx_holding
// RULE2: shifters never visible to software
// RULE3: rx_holding 8 bits, read-only, resets zero
// RULE4: rx_shifter takes next frame immediately; in sync mode the receiver waits until rx_full_flag clears
// RULE5: software reads rx_holding once after full
// RULE6: tx_shifter sends data LSB first
// RULE7: empty tx_shifter loads tx_holding, starts
// RULE8: pending tx_holding loads at frame end
// RULE9: tx_holding 8 bits, resets all ones
// RULE10: software writes tx_holding once when empty
// RULE11: format bit 7 selects async or sync
// RULE12: format bit 6 selects seven data bits
// RULE13: format bit 5 adds and checks parity
// RULE14: format bit 4 picks odd parity
// RULE15: format bit 3 sends two stop bits
// RULE16: receiver checks first stop bit only
// RULE17: format bit 2 multiprocessor, overrides parity
// RULE18: software clears multiprocessor bit in sync
// RULE19: format bits 1:0 select baud prescaler
// RULE20: rx_shifter fills LSB first
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "sfd_consts.vh"
module sfd_serial_unit #(
    parameter DIV_W = 8
) (
    input wire clock_in, // system clock phi
    input wire rst_in, // sync reset, high
    input wire ce_in, // clock enable
    input wire [`SFD_ADDR_W-1:0] addr_in, // register address
    input wire [7:0] wdata_in, // write data
    input wire wr_in, // write strobe
    input wire rd_in, // read strobe
    output reg [7:0] rdata_out, // read data, cycle after rd_in
    input wire rxd_in, // serial data in
    output reg txd_out, // serial data out
    output reg sck_out, // sync clock out
    output wire sck_oe_out, // sck pin driven
    output wire rx_full_out, // rx_full_flag
    output wire tx_empty_out, // tx_empty_flag
    output wire tx_end_out, // transmitter idle
    output wire prescale_out // baud prescaler pulse
);
    localparam TX_IDLE = 5'b00001;
    localparam TX_START = 5'b00010;
    localparam TX_DATA = 5'b00100;
    localparam TX_PAR = 5'b01000;
    localparam TX_STOP = 5'b10000;
    localparam RX_IDLE = 5'b00001;
    localparam RX_START = 5'b00010;
    localparam RX_DATA = 5'b00100;
    localparam RX_PAR = 5'b01000;
    localparam RX_STOP = 5'b10000;

    // even parity; seven-bit mode skips bit 7
    function par_of;
        input [7:0] d;
        input seven;
        begin
            par_of = seven ? ^d[6:0] : ^d;
        end
    endfunction

    reg [7:0] format_r;
    reg [DIV_W-1:0] divisor_r;
    reg [7:0] control_r;
    reg [7:0] tx_holding_r;
    reg [7:0] rx_holding_r;
    reg tx_empty_r, rx_full_r, overrun_r, framing_r, parity_err_r, tx_end_r;
    reg mpb_rx_r, mpb_tx_r;
    reg [4:0] tx_st_r;
    reg [7:0] tx_shifter_r;
    reg [2:0] tx_idx_r;
    reg [3:0] tx_ph_r;
    reg tx_extra_r, tx_bit_r;
    reg [4:0] rx_st_r;
    reg [7:0] rx_shifter_r;
    reg [2:0] rx_idx_r;
    reg [3:0] rx_ph_r;
    reg rx_pbit_r;
    reg rx_s1_r, rx_s2_r, rx_s3_r, rx_f_r;
    wire tick;

    sfd_baud_gen #(
        .DIV_W(DIV_W)
    ) u_baud (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        // RULE19: prescale select
        .sel_in({format_r[`SFD_FMT_CKS_HI], format_r[`SFD_FMT_CKS_LO]}),
        .divisor_in(divisor_r),
        .prescale_out(prescale_out),
        .tick_out(tick)
    );

    // ==========================================================
    // format decode
    // RULE11: mode select
    wire sync_m = format_r[`SFD_FMT_SYNC];
    // RULE12: length ignored in sync
    wire seven = format_r[`SFD_FMT_SEVEN] & ~sync_m;
    // RULE17: mp wins over parity
    wire mp_on = format_r[`SFD_FMT_MP] & ~sync_m;
    // RULE13: parity in async only
    wire par_on = format_r[`SFD_FMT_PAREN] & ~sync_m & ~mp_on;
    // RULE14: odd select
    wire odd = format_r[`SFD_FMT_ODD];
    wire [2:0] last_idx = seven ? `SFD_IDX_LAST7 : `SFD_IDX_LAST8;
    wire tx_en = control_r[`SFD_CTL_TXEN];
    wire rx_en = control_r[`SFD_CTL_RXEN];

    wire wr_tx = wr_in && (addr_in == `SFD_OFS_TXHOLD);
    wire wr_st = wr_in && (addr_in == `SFD_OFS_STATUS);

    // ==========================================================
    // transmitter
    wire tx_adv = tick && (tx_ph_r == `SFD_PH_LAST);
    wire tx_frame_end = tx_adv && (((tx_st_r == TX_DATA) && sync_m && (tx_idx_r == last_idx))
        || ((tx_st_r == TX_STOP) && !(format_r[`SFD_FMT_STOP2] && !tx_extra_r)));
    // RULE7: load when shifter empty
    // RULE8: back-to-back reload
    wire tx_load = ((tx_st_r == TX_IDLE) || tx_frame_end) && tx_en && !tx_empty_r;

    always @(posedge clock_in) begin
        if (rst_in) begin
            tx_st_r <= TX_IDLE;
            tx_shifter_r <= `SFD_RST_TXHOLD;
            tx_idx_r <= 3'h0;
            tx_ph_r <= 4'h0;
            tx_extra_r <= 1'b0;
            tx_bit_r <= 1'b0;
        end else if (ce_in) begin
            if (tick && (tx_st_r != TX_IDLE)) begin
                tx_ph_r <= tx_ph_r + 4'h1;
            end
            if (tx_load) begin
                tx_shifter_r <= tx_holding_r;
                tx_idx_r <= 3'h0;
                tx_ph_r <= 4'h0;
                tx_extra_r <= 1'b0;
                // RULE13: parity or mp bit
                tx_bit_r <= mp_on ? mpb_tx_r : (par_of(tx_holding_r, seven) ^ odd);
                tx_st_r <= sync_m ? TX_DATA : TX_START;
            end else if (tx_frame_end) begin
                tx_st_r <= TX_IDLE;
            end else if (tx_adv) begin
                case (tx_st_r)
                    TX_START: begin
                        tx_st_r <= TX_DATA;
                    end
                    TX_DATA: begin
                        // RULE6: shift out LSB first
                        tx_shifter_r <= {1'b1, tx_shifter_r[7:1]};
                        tx_idx_r <= tx_idx_r + 3'h1;
                        if (tx_idx_r == last_idx) begin
                            tx_st_r <= (par_on || mp_on) ? TX_PAR : TX_STOP;
                        end
                    end
                    TX_PAR: begin
                        tx_st_r <= TX_STOP;
                    end
                    TX_STOP: begin
                        // RULE15: second stop bit
                        tx_extra_r <= 1'b1;
                    end
                    default: begin
                        tx_st_r <= TX_IDLE;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // receiver; three-flop input filter
    wire rx_samp = tick && (rx_ph_r == (sync_m ? `SFD_PH_MID : `SFD_PH_LAST));
    wire rx_adv = tick && (rx_ph_r == `SFD_PH_LAST);
    wire rx_done = rx_adv && ((rx_st_r == RX_STOP)
        || ((rx_st_r == RX_DATA) && sync_m && (rx_idx_r == last_idx)));
    wire [7:0] rx_word = seven ? {1'b0, rx_shifter_r[7:1]} : rx_shifter_r;
    // RULE16: first stop bit only
    wire stop_bad = (rx_st_r == RX_STOP) && !rx_f_r;
    wire par_bad = par_on && ((par_of(rx_word, seven) ^ odd) != rx_pbit_r);

    always @(posedge clock_in) begin
        if (rst_in) begin
            rx_s1_r <= 1'b1;
            rx_s2_r <= 1'b1;
            rx_s3_r <= 1'b1;
            rx_f_r <= 1'b1;
            rx_st_r <= RX_IDLE;
            rx_shifter_r <= `SFD_ZERO8;
            rx_idx_r <= 3'h0;
            rx_ph_r <= 4'h0;
            rx_pbit_r <= 1'b0;
        end else if (ce_in) begin
            rx_s1_r <= rxd_in;
            rx_s2_r <= rx_s1_r;
            rx_s3_r <= rx_s2_r;
            if (rx_s2_r == rx_s3_r) begin
                rx_f_r <= rx_s3_r;
            end
            if (tick && (rx_st_r != RX_IDLE)) begin
                rx_ph_r <= rx_ph_r + 4'h1;
            end
            case (rx_st_r)
                RX_IDLE: begin
                    rx_ph_r <= 4'h0;
                    rx_idx_r <= 3'h0;
                    if (rx_en && sync_m && !rx_full_r) begin
                        rx_st_r <= RX_DATA;
                    end else if (rx_en && !sync_m && !rx_f_r) begin
                        rx_st_r <= RX_START;
                    end
                end
                RX_START: begin
                    // mid-bit confirm centres later samples
                    if (tick && (rx_ph_r == `SFD_PH_MID)) begin
                        rx_ph_r <= 4'h0;
                        rx_st_r <= rx_f_r ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_samp) begin
                        // RULE20: LSB arrives first
                        rx_shifter_r <= {rx_f_r, rx_shifter_r[7:1]};
                    end
                    if (rx_adv) begin
                        rx_idx_r <= rx_idx_r + 3'h1;
                        if (rx_idx_r == last_idx) begin
                            if (sync_m) begin
                                rx_st_r <= RX_IDLE;
                            end else begin
                                rx_st_r <= (par_on || mp_on) ? RX_PAR : RX_STOP;
                            end
                        end
                    end
                end
                RX_PAR: begin
                    if (rx_adv) begin
                        rx_pbit_r <= rx_f_r;
                        rx_st_r <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    // RULE4: next frame at once
                    if (rx_adv) begin
                        rx_st_r <= RX_IDLE;
                    end
                end
                default: begin
                    rx_st_r <= RX_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // registers and flags; receive flags: hardware set beats clear, tx flags: write beats set
    always @(posedge clock_in) begin
        if (rst_in) begin
            format_r <= `SFD_RST_FORMAT;
            divisor_r <= {DIV_W{1'b1}};
            control_r <= `SFD_RST_CONTROL;
            // RULE9: reset all ones
            tx_holding_r <= `SFD_RST_TXHOLD;
            // RULE3: reset zero
            rx_holding_r <= `SFD_RST_RXHOLD;
            tx_empty_r <= 1'b1;
            tx_end_r <= 1'b1;
            rx_full_r <= 1'b0;
            overrun_r <= 1'b0;
            framing_r <= 1'b0;
            parity_err_r <= 1'b0;
            mpb_rx_r <= 1'b0;
            mpb_tx_r <= 1'b0;
        end else if (ce_in) begin
            if (wr_in && (addr_in == `SFD_OFS_FORMAT)) begin
                format_r <= wdata_in;
            end else if (wr_in && (addr_in == `SFD_OFS_DIVISOR)) begin
                divisor_r <= wdata_in[DIV_W-1:0];
            end else if (wr_in && (addr_in == `SFD_OFS_CONTROL)) begin
                control_r <= wdata_in;
            end else if (wr_tx) begin
                tx_holding_r <= wdata_in;
            end
            // RULE3: no write path to rx_holding
            if (wr_tx) begin
                tx_empty_r <= 1'b0;
                tx_end_r <= 1'b0;
            end else if (tx_load) begin
                tx_empty_r <= 1'b1;
            end
            if (tx_frame_end && !tx_load && !wr_tx) begin
                tx_end_r <= 1'b1;
            end
            if (wr_st) begin
                mpb_tx_r <= wdata_in[`SFD_ST_MPB_TX];
                if (!wdata_in[`SFD_ST_RXFULL]) rx_full_r <= 1'b0;
                if (!wdata_in[`SFD_ST_OVERRUN]) overrun_r <= 1'b0;
                if (!wdata_in[`SFD_ST_FRAMING]) framing_r <= 1'b0;
                if (!wdata_in[`SFD_ST_PARITY]) parity_err_r <= 1'b0;
            end
            if (rx_done) begin
                if (rx_full_r) begin
                    // unread word kept, loss flagged
                    overrun_r <= 1'b1;
                end else begin
                    // RULE1: frame into rx_holding
                    rx_holding_r <= rx_word;
                    rx_full_r <= 1'b1;
                    if (stop_bad) framing_r <= 1'b1;
                    if (par_bad) parity_err_r <= 1'b1;
                    if (mp_on) mpb_rx_r <= rx_pbit_r;
                end
            end
        end
    end

    // ==========================================================
    // read port and pins
    wire [7:0] status = {tx_empty_r, rx_full_r, overrun_r, framing_r,
                         parity_err_r, tx_end_r, mpb_rx_r, mpb_tx_r};
    wire tx_busy_sync = sync_m && (tx_st_r == TX_DATA);
    wire rx_busy_sync = sync_m && (rx_st_r == RX_DATA);

    always @(posedge clock_in) begin
        if (rst_in) begin
            rdata_out <= `SFD_ZERO8;
            txd_out <= 1'b1;
            sck_out <= 1'b1;
        end else if (ce_in) begin
            // RULE2: shifters have no address
            if (!rd_in) begin
                rdata_out <= `SFD_ZERO8;
            end else if (addr_in == `SFD_OFS_FORMAT) begin
                rdata_out <= format_r;
            end else if (addr_in == `SFD_OFS_DIVISOR) begin
                rdata_out <= {{(8-DIV_W){1'b0}}, divisor_r};
            end else if (addr_in == `SFD_OFS_CONTROL) begin
                rdata_out <= control_r;
            end else if (addr_in == `SFD_OFS_TXHOLD) begin
                rdata_out <= tx_holding_r;
            end else if (addr_in == `SFD_OFS_STATUS) begin
                rdata_out <= status;
            end else if (addr_in == `SFD_OFS_RXHOLD) begin
                rdata_out <= rx_holding_r;
            end else begin
                rdata_out <= `SFD_ZERO8;
            end
            case (tx_st_r)
                TX_START: txd_out <= 1'b0;
                TX_DATA: txd_out <= tx_shifter_r[0];
                TX_PAR: txd_out <= tx_bit_r;
                default: txd_out <= 1'b1;
            endcase
            // clock rises at mid-bit
            if (tx_busy_sync) begin
                sck_out <= (tx_ph_r > `SFD_PH_MID);
            end else if (rx_busy_sync) begin
                sck_out <= (rx_ph_r > `SFD_PH_MID);
            end else begin
                sck_out <= 1'b1;
            end
        end
    end

    assign sck_oe_out = sync_m;
    assign rx_full_out = rx_full_r;
    assign tx_empty_out = tx_empty_r;
    assign tx_end_out = tx_end_r;
endmodule
`default_nettype wire

// ===== sfd_serial_unit_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// port checker
module sfd_serial_unit_monitor (
    input wire logic clock_in, // system clock
    input wire logic rst_in, // sync reset, high
    input wire logic ce_in, // clock enable
    input wire logic [2:0] addr_in, // register address
    input wire logic wr_in, // write strobe
    input wire logic rd_in, // read strobe
    input wire logic [7:0] rdata_out, // read data
    input wire logic txd_out, // serial out
    input wire logic sck_out, // sync clock
    input wire logic sck_oe_out, // sync clock driven
    input wire logic rx_full_out, // receive full
    input wire logic tx_empty_out, // transmit empty
    input wire logic tx_end_out, // transmitter idle
    input wire logic prescale_out // prescaler pulse
);
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (rst_in);
    // ==========
    // sequences
    sequence s_tx_write;
        ce_in && wr_in && addr_in == 3'h3;
    endsequence
    // bit held 8 clocks after each change
    sequence s_bit_hold;
        $stable(txd_out) [*8];
    endsequence
    // ==========
    // properties
    property p_reset_state;
        $past(rst_in) |-> rdata_out == 8'h00 && !rx_full_out && tx_empty_out && tx_end_out
            && txd_out && sck_out && !sck_oe_out && !prescale_out;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("reset state");
    property p_read_idle;
        $past(ce_in) && !$past(rd_in) |-> rdata_out == 8'h00;
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("stray read data");
    property p_unmapped;
        ce_in && rd_in && addr_in[2:1] == 2'b11 |=> rdata_out == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_tx_take;
        s_tx_write |=> !tx_empty_out && !tx_end_out;
    endproperty
    a_tx_take: assert property (p_tx_take) else $error("write not taken");
    property p_bit_hold;
        $changed(txd_out) |=> s_bit_hold;
    endproperty
    a_bit_hold: assert property (p_bit_hold) else $error("bit too short");
    property p_txd_idle;
        tx_end_out && $past(tx_end_out) |-> txd_out;
    endproperty
    a_txd_idle: assert property (p_txd_idle) else $error("idle line low");
    property p_sck_idle;
        !sck_oe_out |-> sck_out;
    endproperty
    a_sck_idle: assert property (p_sck_idle) else $error("clock moves");
    property p_rx_keep;
        ce_in && rd_in && addr_in == 3'h5 && rx_full_out |=> rx_full_out;
    endproperty
    a_rx_keep: assert property (p_rx_keep) else $error("full cleared");
endmodule
`default_nettype wire

// ===== sfd_remote_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// remote end, 16 clocks a bit
module sfd_remote_model (
    input wire logic clock_in, // system clock
    input wire logic txd_in, // device serial out
    input wire logic sck_in, // device sync clock
    output logic rxd_out // device serial in
);
    localparam int BIT = 16;
    initial rxd_out = 1'b1;
    // line stays at the last bit sent
    task automatic send(input logic [11:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            rxd_out <= bits[i];
            repeat (BIT) @(posedge clock_in);
        end
    endtask
    // no wait after last sample, next start kept
    task automatic get(input int n, output logic [11:0] bits, output time t0);
        bits = 12'hfff;
        @(negedge txd_in);
        t0 = $time;
        repeat (BIT / 2) @(posedge clock_in);
        for (int i = 0; i < n; i++) begin
            bits[i] = txd_in;
            if (i < n - 1) repeat (BIT) @(posedge clock_in);
        end
    endtask
    task automatic get_sync(output logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            @(posedge sck_in);
            d[i] = txd_in;
        end
    endtask
endmodule
`default_nettype wire

// ===== sfd_serial_unit_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sfd_serial_unit_bench;
    localparam time BIT_NS = 320;
    logic clock_in, rst_in, ce_in, wr_in, rd_in, rxd_in;
    logic [2:0] addr_in;
    logic [7:0] wdata_in, rdata_out, rv, da, db, m;
    logic txd_out, sck_out, sck_oe_out, rx_full_out, tx_empty_out, tx_end_out, prescale_out;
    logic [11:0] ea, eb, fa, fb;
    time ta, tb;
    int fails, total_checks, seed, n, cnt;
    logic [7:0] fmts [6] = '{8'h00, 8'h40, 8'h20, 8'h38, 8'h28, 8'h24};
    logic [2:0] ra [5] = '{3'h5, 3'h3, 3'h0, 3'h6, 3'h7};
    logic [7:0] re [5] = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
    sfd_serial_unit #(.DIV_W(8)) u_sfd_serial_unit (
        .clock_in(clock_in), .rst_in(rst_in), .ce_in(ce_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .rxd_in(rxd_in), .txd_out(txd_out), .sck_out(sck_out), .sck_oe_out(sck_oe_out),
        .rx_full_out(rx_full_out), .tx_empty_out(tx_empty_out), .tx_end_out(tx_end_out),
        .prescale_out(prescale_out)
    );
    sfd_remote_model u_sfd_remote_model (
        .clock_in(clock_in), .txd_in(txd_out), .sck_in(sck_out), .rxd_out(rxd_in)
    );
    initial begin
        clock_in = 1'b0;
        forever #10 clock_in = ~clock_in;
    end
    // ==========
    // helpers
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clock_in);
        wr_in <= 1'b0;
        @(posedge clock_in);
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clock_in);
        rd_in <= 1'b0;
        @(posedge clock_in);
        d = rdata_out;
    endtask
    function automatic logic flag(input int w);
        return w == 0 ? tx_empty_out : (w == 1 ? rx_full_out : tx_end_out);
    endfunction
    task automatic wait_flag(input int w, input int lim);
        int c;
        c = 0;
        @(posedge clock_in);
        while (flag(w) !== 1'b1 && c < lim) begin
            @(posedge clock_in);
            c++;
        end
        chk({11'h000, flag(w)}, 12'h001);
    endtask
    // expected line, lsb first
    function automatic logic [11:0] frame(input logic [7:0] f, input logic [7:0] d,
                                          output int len);
        logic [11:0] b;
        int nd;
        nd = f[6] ? 7 : 8;
        b = 12'hfff;
        b[0] = 1'b0;
        for (int i = 0; i < nd; i++) b[i + 1] = d[i];
        len = nd + 1;
        if (f[2] || f[5]) begin
            b[len] = f[2] ? 1'b0 : ^(d & (f[6] ? 8'h7f : 8'hff)) ^ f[4];
            len++;
        end
        len = len + 1 + f[3];
        return b;
    endfunction
    task automatic take(input logic [7:0] e, input logic [3:0] st);
        wait_flag(1, 400);
        rd(3'h4, rv);
        chk({8'h00, rv[6:3]}, {8'h00, st});
        rd(3'h5, rv);
        chk({4'h0, rv}, {4'h0, e});
        wr(3'h4, 8'h00);
    endtask
    task automatic report_and_stop();
        $display("checks=%0d fails=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #1_000_000;
        fails++;
        report_and_stop();
    end
    // ==========
    // main sequence
    initial begin
        seed = 32'h1a27ca74;
        fails = 0;
        total_checks = 0;
        rst_in = 1'b1;
        ce_in = 1'b1;
        wr_in = 1'b0;
        rd_in = 1'b0;
        addr_in = 3'h0;
        wdata_in = 8'h00;
        repeat (4) @(posedge clock_in);
        rst_in <= 1'b0;
        @(posedge clock_in);
        wr(3'h5, 8'h5a);
        for (int i = 0; i < 5; i++) begin
            rd(ra[i], rv);
            chk({4'h0, rv}, {4'h0, re[i]});
        end
        wr(3'h1, 8'h00);
        wr(3'h2, 8'h03);
        for (int k = 0; k < 6; k++) begin
            wr(3'h0, fmts[k]);
            da = 8'($random(seed));
            db = 8'($random(seed));
            if (k == 0) da = 8'h00;
            if (k == 1) db = 8'hff;
            m = fmts[k][6] ? 8'h7f : 8'hff;
            ea = frame(fmts[k], da, n);
            eb = frame(fmts[k], db, n);
            fork
                begin
                    u_sfd_remote_model.get(n, fa, ta);
                    u_sfd_remote_model.get(n, fb, tb);
                end
                begin
                    wr(3'h3, da);
                    wait_flag(0, 20);
                    wr(3'h3, db);
                end
            join
            chk(fa, ea);
            chk(fb, eb);
            chk({11'h000, tb - ta == n * BIT_NS}, 12'h001);
            wait_flag(2, 400);
            // second start lands in stop two for two-stop formats
            fork
                begin
                    u_sfd_remote_model.send(ea, n - fmts[k][3]);
                    u_sfd_remote_model.send(eb, n);
                end
                begin
                    take(da & m, 4'h8);
                    take(db & m, 4'h8);
                end
            join
        end
        wr(3'h0, 8'h20);
        ea = frame(8'h20, 8'h5c, n);
        ea[9] = ~ea[9];
        eb = frame(8'h20, 8'h3a, n);
        eb[10] = 1'b0;
        fork
            begin
                u_sfd_remote_model.send(ea, n);
                u_sfd_remote_model.send(eb, n + 1);
            end
            begin
                take(8'h5c, 4'h9);
                take(8'h3a, 4'ha);
            end
        join
        // frozen writes lost
        ce_in <= 1'b0;
        wr(3'h0, 8'h55);
        ce_in <= 1'b1;
        rd(3'h0, rv);
        chk({4'h0, rv}, 12'h020);
        wr(3'h2, 8'h01);
        wr(3'h0, 8'hc0);
        da = 8'($random(seed));
        fork
            u_sfd_remote_model.get_sync(db);
            wr(3'h3, da);
        join
        chk({11'h000, sck_oe_out}, 12'h001);
        chk({4'h0, db}, {4'h0, da});
        wait_flag(2, 400);
        for (int s = 0; s < 4; s++) begin
            wr(3'h0, 8'(s));
            repeat (64) @(posedge clock_in);
            cnt = 0;
            repeat (256) begin
                @(posedge clock_in);
                cnt += prescale_out;
            end
            chk(cnt[11:0], 12'(256 >> (2 * s)));
        end
        wr(3'h3, 8'h3c);
        rst_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        rst_in <= 1'b0;
        @(posedge clock_in);
        rd(3'h3, rv);
        chk({4'h0, rv}, 12'h0ff);
        report_and_stop();
    end
endmodule
bind sfd_serial_unit sfd_serial_unit_monitor u_sfd_serial_unit_monitor (
    .clock_in(clock_in), .rst_in(rst_in), .ce_in(ce_in), .addr_in(addr_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .txd_out(txd_out),
    .sck_out(sck_out), .sck_oe_out(sck_oe_out), .rx_full_out(rx_full_out),
    .tx_empty_out(tx_empty_out), .tx_end_out(tx_end_out), .prescale_out(prescale_out)
);
`default_nettype wire
